// ---- shared/pgh_pkg.sv ----
// Constants and types shared by the port G/H pin function select block
package pgh_pkg;

  // Register bus geometry
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 4;

  // Register offsets
  localparam logic [3:0] OFF_G_CTRL = 4'h0;
  localparam logic [3:0] OFF_H_CTRL = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_LEVEL = 4'h6;

  // Port G control: reset values and reserved bits
  localparam logic [15:0] G_RESET_EMU = 16'haaaa;
  localparam logic [15:0] G_RESET_NORM = 16'ha800;
  localparam logic [15:0] G_READ_ONES = 16'ha000;
  localparam logic [15:0] G_FIELD_MASK = 16'h0fff;

  // Port H control: reset value and writable bits
  localparam logic [15:0] H_RESET = 16'h0000;
  localparam logic [15:0] H_FIELD_MASK = 16'h3fff;

  // Pin counts and field positions
  localparam int unsigned G_PINS = 6;
  localparam int unsigned H_PINS = 4;
  localparam int unsigned H_FIRST_PIN = 3;
  localparam int unsigned MODE_W = 2;

  // Status register fields
  localparam int unsigned STAT_G_BAD_LSB = 0;
  localparam int unsigned STAT_STRAP_BIT = 8;

  // Pin level register fields
  localparam int unsigned LVL_G_LSB = 0;
  localparam int unsigned LVL_H_LSB = 8;

  // Input filter depth: two matching late stages accept a change
  localparam int unsigned SYNC_STAGES = 3;

  // Pin mode field encodings
  typedef enum logic [1:0] {
    PGH_MODE_PERIPH = 2'b00,
    PGH_MODE_PORT_OUT = 2'b01,
    PGH_MODE_IN_PULL = 2'b10,
    PGH_MODE_IN_NOPULL = 2'b11
  } pgh_mode_t;

endpackage

// ---- src/pgh_pin_cell.sv ----
// One pin: mode decode, pad drive, pull-up and filtered input
`timescale 1ns/1ps
module pgh_pin_cell #(
  parameter bit HAS_PORT_OUT = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Mode from the control register
  input wire logic [1:0] mode,
  // Pad side
  input wire logic pad_in,
  output logic pad_out_q,
  output logic pad_oe_q,
  output logic pull_en_q,
  // Peripheral side
  input wire logic periph_out,
  input wire logic periph_oe,
  output logic periph_in_q,
  // Port data side
  input wire logic port_data,
  output logic level_q
);

  logic [pgh_pkg::SYNC_STAGES-1:0] sync_q;
  logic level_d;
  logic pad_out_d;
  logic pad_oe_d;
  logic pull_en_d;
  logic periph_in_d;

  always_comb begin
    // Late stages only; the first stage feeds nothing but the second
    level_d = level_q;
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
    end
    pad_out_d = 1'b0;
    pad_oe_d = 1'b0;
    pull_en_d = 1'b0;
    periph_in_d = 1'b0;
    unique case (pgh_pkg::pgh_mode_t'(mode))
      pgh_pkg::PGH_MODE_PERIPH: begin
        pad_out_d = periph_out;
        pad_oe_d = periph_oe;
        periph_in_d = level_q;
      end
      pgh_pkg::PGH_MODE_PORT_OUT: begin
        // Prohibited code on an input-only pin parks it as plain input
        pad_out_d = HAS_PORT_OUT ? port_data : 1'b0;
        pad_oe_d = HAS_PORT_OUT;
      end
      pgh_pkg::PGH_MODE_IN_PULL: begin
        pull_en_d = 1'b1;
      end
      pgh_pkg::PGH_MODE_IN_NOPULL: begin
        pull_en_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_q <= '0;
      level_q <= 1'b0;
      pad_out_q <= 1'b0;
      pad_oe_q <= 1'b0;
      pull_en_q <= 1'b0;
      periph_in_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], pad_in};
      level_q <= level_d;
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
      pull_en_q <= pull_en_d;
      periph_in_q <= periph_in_d;
    end
  end

endmodule

// ---- src/pgh_pin_select.sv ----
// Port G/H pin function select: control registers, bus slave, pin cells
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
//
// Contract
// - Port G control register is 16 bits, readable and writable.
// - Power-on reset loads port G with aaaa if strap high, a800 if low.
// - Port G keeps contents across manual reset, standby and sleep.
// - Port G bits 15 and 13 read one; writes to them do nothing.
// - Port G bits 14 and 12 read zero; writes to them do nothing.
// - Mode 00 peripheral, 10 input with pull-up, 11 input without.
// - Port H control register is 16 bits; mode 01 drives a port output.
// - Port H bits 15 and 14 read zero; software writes zero there.
// - Port G fields at bits 11:0 pins 5-0; H pins 6-3 at 13:6.
module pgh_pin_select (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst,
  // Strap sampled for the port G reset value
  input wire logic emulation_mode_strap,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  // Port G pads
  input wire logic [5:0] grp_g_pad_in,
  output logic [5:0] grp_g_pad_out_q,
  output logic [5:0] grp_g_pad_oe_q,
  output logic [5:0] grp_g_pull_en_q,
  // Port G peripheral functions
  input wire logic [5:0] grp_g_periph_out,
  input wire logic [5:0] grp_g_periph_oe,
  output logic [5:0] grp_g_periph_in_q,
  // Port G filtered pin levels
  output logic [5:0] grp_g_level_q,
  // Port H pads, pins 6 down to 3
  input wire logic [3:0] grp_h_pad_in,
  output logic [3:0] grp_h_pad_out_q,
  output logic [3:0] grp_h_pad_oe_q,
  output logic [3:0] grp_h_pull_en_q,
  // Port H peripheral functions
  input wire logic [3:0] grp_h_periph_out,
  input wire logic [3:0] grp_h_periph_oe,
  output logic [3:0] grp_h_periph_in_q,
  // Port H output data and filtered pin levels
  input wire logic [3:0] grp_h_port_data,
  output logic [3:0] grp_h_level_q
);

  // Strap filter: no reset, so it keeps tracking the pin while rst holds
  logic [pgh_pkg::SYNC_STAGES-1:0] strap_sync_q;
  logic strap_lvl_q;
  logic strap_lvl_d;

  // Control registers, only writable bits stored
  logic [15:0] g_ctrl_q;
  logic [15:0] g_ctrl_d;
  logic [15:0] h_ctrl_q;
  logic [15:0] h_ctrl_d;

  // Read path
  logic [15:0] reg_rdata_d;
  logic [15:0] g_view;
  logic [15:0] h_view;
  logic [15:0] status_view;
  logic [15:0] level_view;

  // Decode
  logic sel_g;
  logic sel_h;
  logic sel_status;
  logic sel_level;

  // Per-pin mode fields
  logic [1:0] g_mode [pgh_pkg::G_PINS];
  logic [1:0] h_mode [pgh_pkg::H_PINS];
  logic [5:0] g_bad_code;

  assign sel_g = (reg_addr == pgh_pkg::OFF_G_CTRL);
  assign sel_h = (reg_addr == pgh_pkg::OFF_H_CTRL);
  assign sel_status = (reg_addr == pgh_pkg::OFF_STATUS);
  assign sel_level = (reg_addr == pgh_pkg::OFF_LEVEL);

  // Strap filter
  always_comb begin
    strap_lvl_d = strap_lvl_q;
    if (strap_sync_q[1] == strap_sync_q[2]) begin
      strap_lvl_d = strap_sync_q[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    strap_sync_q <= {strap_sync_q[1:0], emulation_mode_strap};
    strap_lvl_q <= strap_lvl_d;
  end

  // Port G control register
  always_comb begin
    g_ctrl_d = g_ctrl_q;
    if (rst) begin
      g_ctrl_d = strap_lvl_q ? pgh_pkg::G_RESET_EMU : pgh_pkg::G_RESET_NORM;
      g_ctrl_d = g_ctrl_d & pgh_pkg::G_FIELD_MASK;
    end else if (reg_wr && sel_g) begin
      g_ctrl_d = reg_wdata & pgh_pkg::G_FIELD_MASK;
    end
  end

  // power-on reset is the only clearing term
  always_ff @(posedge ref_clk) begin
    g_ctrl_q <= g_ctrl_d;
  end

  // Port H control register
  always_comb begin
    h_ctrl_d = h_ctrl_q;
    if (reg_wr && sel_h) begin
      h_ctrl_d = reg_wdata & pgh_pkg::H_FIELD_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      h_ctrl_q <= pgh_pkg::H_RESET;
    end else begin
      h_ctrl_q <= h_ctrl_d;
    end
  end

  // Register views
  always_comb begin
    g_view = (g_ctrl_q & pgh_pkg::G_FIELD_MASK) | pgh_pkg::G_READ_ONES;
    h_view = h_ctrl_q & pgh_pkg::H_FIELD_MASK;
    status_view = '0;
    status_view[pgh_pkg::STAT_G_BAD_LSB +: pgh_pkg::G_PINS] = g_bad_code;
    status_view[pgh_pkg::STAT_STRAP_BIT] = strap_lvl_q;
    level_view = '0;
    level_view[pgh_pkg::LVL_G_LSB +: pgh_pkg::G_PINS] = grp_g_level_q;
    level_view[pgh_pkg::LVL_H_LSB + pgh_pkg::H_FIRST_PIN +: pgh_pkg::H_PINS] =
      grp_h_level_q;
  end

  // Read data: valid only in the cycle after the strobe
  always_comb begin
    reg_rdata_d = '0;
    if (reg_rd) begin
      unique case (1'b1)
        sel_g: begin
          reg_rdata_d = g_view;
        end
        sel_h: begin
          reg_rdata_d = h_view;
        end
        sel_status: begin
          reg_rdata_d = status_view;
        end
        sel_level: begin
          reg_rdata_d = level_view;
        end
        default: begin
          reg_rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Port G pins: input-only cells, code 01 is parked as input
  for (genvar i = 0; i < pgh_pkg::G_PINS; i++) begin : g_pin
    assign g_mode[i] = g_ctrl_q[pgh_pkg::MODE_W*i +: pgh_pkg::MODE_W];
    assign g_bad_code[i] = (g_mode[i] == pgh_pkg::PGH_MODE_PORT_OUT);

    pgh_pin_cell #(
      .HAS_PORT_OUT(1'b0)
    ) u_cell (
      .ref_clk(ref_clk),
      .rst(rst),
      .mode(g_mode[i]),
      .pad_in(grp_g_pad_in[i]),
      .pad_out_q(grp_g_pad_out_q[i]),
      .pad_oe_q(grp_g_pad_oe_q[i]),
      .pull_en_q(grp_g_pull_en_q[i]),
      .periph_out(grp_g_periph_out[i]),
      .periph_oe(grp_g_periph_oe[i]),
      .periph_in_q(grp_g_periph_in_q[i]),
      .port_data(1'b0),
      .level_q(grp_g_level_q[i])
    );
  end

  // Port H pins 3 to 6: full cells with port output
  for (genvar j = 0; j < pgh_pkg::H_PINS; j++) begin : h_pin
    assign h_mode[j] =
      h_ctrl_q[pgh_pkg::MODE_W*(j+pgh_pkg::H_FIRST_PIN) +: pgh_pkg::MODE_W];

    pgh_pin_cell #(
      .HAS_PORT_OUT(1'b1)
    ) u_cell (
      .ref_clk(ref_clk),
      .rst(rst),
      .mode(h_mode[j]),
      .pad_in(grp_h_pad_in[j]),
      .pad_out_q(grp_h_pad_out_q[j]),
      .pad_oe_q(grp_h_pad_oe_q[j]),
      .pull_en_q(grp_h_pull_en_q[j]),
      .periph_out(grp_h_periph_out[j]),
      .periph_oe(grp_h_periph_oe[j]),
      .periph_in_q(grp_h_periph_in_q[j]),
      .port_data(grp_h_port_data[j]),
      .level_q(grp_h_level_q[j])
    );
  end

endmodule

// ---- testbench/pgh_monitor.sv ----
// Port-level assertions for the pin function select block
`timescale 1ns/1ps
module pgh_monitor (
  // Clock, reset, strap
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic emulation_mode_strap,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_q,
  // Pads
  input wire logic [5:0] grp_g_pad_oe_q,
  input wire logic [5:0] grp_g_pull_en_q,
  input wire logic [5:0] grp_g_periph_oe,
  input wire logic [3:0] grp_h_pad_out_q,
  input wire logic [3:0] grp_h_pad_oe_q,
  input wire logic [3:0] grp_h_pull_en_q,
  input wire logic [3:0] grp_h_periph_oe,
  input wire logic [3:0] grp_h_port_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata_q == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
  property p_g_rsv;
    reg_rd && reg_addr == 4'h0 |=> reg_rdata_q[15:12] == 4'ha;
  endproperty
  a_g_rsv: assert property (p_g_rsv) else $error("port G top bits");
  property p_h_rsv;
    reg_rd && reg_addr == 4'h2 |=> reg_rdata_q[15:14] == 2'b00;
  endproperty
  a_h_rsv: assert property (p_h_rsv) else $error("port H top bits");
  property p_g_wr;
    reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0
      |=> reg_rdata_q[11:0] == $past(reg_wdata[11:0], 2);
  endproperty
  a_g_wr: assert property (p_g_wr) else $error("port G fields");
  property p_strap;
    $fell(rst) |-> ##2 grp_g_pull_en_q == (emulation_mode_strap ? 6'h3f : 6'h20);
  endproperty
  a_strap: assert property (p_strap) else $error("port G reset modes");
  property p_g_drv;
    (grp_g_pad_oe_q & ~$past(grp_g_periph_oe)) == 6'h00;
  endproperty
  a_g_drv: assert property (p_g_drv) else $error("port G drives alone");
  property p_g_pull;
    (grp_g_pull_en_q & grp_g_pad_oe_q) == 6'h00;
  endproperty
  a_g_pull: assert property (p_g_pull) else $error("port G pull with drive");
  property p_h_pull;
    (grp_h_pull_en_q & grp_h_pad_oe_q) == 4'h0;
  endproperty
  a_h_pull: assert property (p_h_pull) else $error("port H pull with drive");
  property p_h_out;
    ((grp_h_pad_out_q ^ $past(grp_h_port_data)) & grp_h_pad_oe_q
      & ~$past(grp_h_periph_oe)) == 4'h0;
  endproperty
  a_h_out: assert property (p_h_out) else $error("port H output data");
  c_g_rd: cover property (reg_rd && reg_addr == 4'h0);
  c_h_out: cover property (|grp_h_pad_oe_q);
  c_g_pull: cover property (|grp_g_pull_en_q);
endmodule
bind pgh_pin_select pgh_monitor pgh_monitor_i (.*);

// ---- testbench/pgh_pin_partner.sv ----
// Pads of one port: block drive, then pull-up, then outside circuit
`timescale 1ns/1ps
module pgh_pin_partner #(
  parameter int W = 6
) (
  // Block side
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pull_en,
  // Outside level seen on released pins
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pad_in
);
  // pull-up holds a released pin high
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : (pull_en[i] ? 1'b1 : ext[i]);
    end
  end
endmodule

// ---- testbench/pgh_pin_select_bench.sv ----
// Self-checking bench for the pin function select block
`timescale 1ns/1ps
module pgh_pin_select_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic [3:0] ad = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] rdq;
  logic [5:0] g_in, g_out, g_oe, g_pull, g_pin, g_lvl;
  logic [5:0] g_ext = 6'h00;
  logic [5:0] g_poe = 6'h3f;
  logic [3:0] h_in, h_out, h_oe, h_pull, h_pin, h_lvl;
  logic [3:0] h_data = 4'hf;
  logic [3:0] h_ext = 4'h0;
  int n_fail = 0;
  int total_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  pgh_pin_select pgh_pin_select_i (.ref_clk(ref_clk), .rst(rst),
    .emulation_mode_strap(strap), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata_q(rdq), .grp_g_pad_in(g_in), .grp_g_pad_out_q(g_out),
    .grp_g_pad_oe_q(g_oe), .grp_g_pull_en_q(g_pull), .grp_g_periph_out(6'h3f),
    .grp_g_periph_oe(g_poe), .grp_g_periph_in_q(g_pin), .grp_g_level_q(g_lvl),
    .grp_h_pad_in(h_in), .grp_h_pad_out_q(h_out), .grp_h_pad_oe_q(h_oe),
    .grp_h_pull_en_q(h_pull), .grp_h_periph_out(4'h0), .grp_h_periph_oe(4'h0),
    .grp_h_periph_in_q(h_pin), .grp_h_port_data(h_data), .grp_h_level_q(h_lvl));
  pgh_pin_partner #(.W(6)) pgh_pin_partner_g_i (.pad_out(g_out), .pad_oe(g_oe),
    .pull_en(g_pull), .ext(g_ext), .pad_in(g_in));
  pgh_pin_partner #(.W(4)) pgh_pin_partner_h_i (.pad_out(h_out), .pad_oe(h_oe),
    .pull_en(h_pull), .ext(h_ext), .pad_in(h_in));
  task chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Callers start right after an edge; never two writes in a row
  task wr(input logic [3:0] a, input logic [15:0] d);
    wr_s <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge ref_clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    rd_s <= 1'b1;
    ad <= a;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1 chk(rdq, e);
  endtask
  task por(input logic s);
    strap <= s;
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    por(1'b1);
    rd(4'h0, 16'haaaa);
    rd(4'h2, 16'h0000);
    chk(16'(g_pull), 16'h003f);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'hafff);
    wr(4'h0, 16'h5000);
    rd(4'h0, 16'ha000);
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'h3fff);
    wr(4'h6, 16'h1234);
    rd(4'hf, 16'h0000);
    // Pins 0..3 take modes 00, 10, 11, 11; code 01 stays off port G
    wr(4'h0, 16'h00f8);
    rd(4'h0, 16'ha0f8);
    wr(4'h2, 16'h0e40);
    rd(4'h2, 16'h0e40);
    repeat (6) @(posedge ref_clk);
    #1 chk(16'(g_oe), 16'h0031);
    chk(16'(g_pull), 16'h0002);
    chk(16'(g_pin), 16'h0031);
    chk(16'(g_lvl), 16'h0033);
    chk(16'(h_oe), 16'h0001);
    chk(16'(h_out & h_oe), 16'h0001);
    chk(16'(h_pull), 16'h0002);
    chk(16'(h_lvl), 16'h0003);
    rd(4'h6, 16'h1833);
    rd(4'h4, 16'h0100);
    h_data <= 4'h0;
    repeat (2) @(posedge ref_clk);
    #1 chk(16'(h_out & h_oe), 16'h0000);
    // Peripheral lets go of its pins; outside drives pins 2 and 3 high
    g_poe <= 6'h00;
    g_ext <= 6'h0c;
    repeat (6) @(posedge ref_clk);
    #1 chk(16'(g_oe), 16'h0000);
    chk(16'(g_lvl), 16'h000e);
    chk(16'(g_pin), 16'h0000);
    @(posedge ref_clk);
    por(1'b0);
    rd(4'h0, 16'ha800);
    rd(4'h2, 16'h0000);
    chk(16'(g_pull), 16'h0020);
    report_and_stop;
  end
endmodule
